// ---- cfp_defs.svh ----
// constants of the current report frame packer
`ifndef CFP_DEFS_SVH
`define CFP_DEFS_SVH

`define CFP_FINE_ZERO     24'h800000
`define CFP_FINE_POS_SAT  24'h97A6B0
`define CFP_FINE_NEG_SAT  24'h685950
`define CFP_FINE_OOR      24'hFFFFFF
`define CFP_COARSE_ZERO   16'h8000
`define CFP_COARSE_POS    16'h860E
`define CFP_COARSE_NEG    16'h79F2
`define CFP_COARSE_CLAMP  16'h060E
`define CFP_CLAMP_MA      32'h0017A6B0
`define CFP_OVERCUR_MA    32'h00186A00
`define CFP_IMAX_MA       32'h0019F0A0
`define CFP_BAND_MA       32'h0016E360
`define CFP_WIN_MA        32'h00035B60
`define CFP_GAP_MA        32'h0000ABE0
`define CFP_MA_PER_A      32'h000003E8
`define CFP_SUPPLY_MIN_MV 16'h1E78
`define CFP_SUPPLY_MAX_MV 16'h3F48
`define CFP_SUPPLY_NONE   2'h3
`define CFP_FRAME_ID      11'h3C2
`define CFP_PERIOD_MS     32'h0000000A
`define CFP_CLK_HZ        32'h00989680
`define CFP_PERIOD_CYC    ((`CFP_PERIOD_MS * `CFP_CLK_HZ) / 32'h000003E8)
`define CFP_SEQ_RESTART   4'h1
`define CFP_SEQ_LAST      4'hF
`define CFP_CRC_POLY      8'h1D
`define CFP_CRC_INIT      8'hFF
`define CFP_CRC_XOR       8'hFF

`endif

// ---- cfp_pkg.sv ----
// types of the current report frame packer
package cfp_pkg;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_RUN,
    ST_SEND,
    ST_MUTE
  } cfp_state_t;

  // byte 0 at the top, so the packed word is sent most significant first
  typedef struct packed {
    logic [3:0]  rolling_frame_count;
    logic [1:0]  supply_state_field;
    logic        fault_flag;
    logic        plausibility_violation_flag;
    logic [23:0] fine_code;
    logic [15:0] coarse_code;
    logic [7:0]  spare_byte;
    logic [7:0]  frame_check_byte;
  } cfp_frame_t;

  typedef struct packed {
    logic signed [31:0] fine_ma;
    logic signed [15:0] coarse_a;
  } cfp_meas_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  state;
    logic [15:0] mv;
  } cfp_supply_t;

  typedef struct packed {
    cfp_state_t  fsm;
    logic [31:0] tick_cnt;
    logic [3:0]  seq;
    cfp_frame_t  frame;
    logic        frame_valid;
    logic        muted;
  } cfp_regs_t;

endpackage : cfp_pkg

// ---- cfp_crc8.sv ----
// bytewise J1850 style CRC-8 over a packed byte string
`include "cfp_defs.svh"

module cfp_crc8 #(
  parameter int NBYTES = 7
) (
  // data, first byte in the top bits
  input  wire logic [8*NBYTES-1:0] data,
  // result after final inversion
  output logic      [7:0]          crc
);

  logic [7:0] acc;

  always_comb begin
    acc = `CFP_CRC_INIT;
    for (int i = NBYTES - 1; i >= 0; i--) begin
      acc = acc ^ data[8*i +: 8];
      for (int b = 0; b < 8; b++) begin
        if (acc[7]) begin
          acc = {acc[6:0], 1'b0} ^ `CFP_CRC_POLY;
        end else begin
          acc = {acc[6:0], 1'b0};
        end
      end
    end
    crc = acc ^ `CFP_CRC_XOR;
  end

endmodule : cfp_crc8

// ---- cfp_packer.sv ----
// periodic current report frame builder with start-up supply gate
`include "cfp_defs.svh"

module cfp_packer #(
  parameter logic        EXTENDED   = 1'b1,
  parameter logic [10:0] FRAME_ID   = `CFP_FRAME_ID,
  parameter int unsigned PERIOD_CYC = `CFP_PERIOD_CYC,
  parameter logic [31:0] IMAX_MA    = `CFP_IMAX_MA
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // measurement front end
  input  wire cfp_pkg::cfp_meas_t   meas,
  input  wire cfp_pkg::cfp_supply_t supply,
  // internal hardware faults
  input  wire logic                 ref_fault,
  input  wire logic                 conv_fault,
  input  wire logic                 ripple_fault,
  // towards the CAN controller
  input  wire logic                 frame_ready,
  output logic                      frame_valid,
  output cfp_pkg::cfp_frame_t       frame,
  output logic [10:0]               frame_id,
  // status
  output logic                      tx_muted
);

  localparam logic [31:0] PERIOD_LAST = 32'(PERIOD_CYC - 1);

  cfp_pkg::cfp_regs_t  q;
  cfp_pkg::cfp_regs_t  d;
  cfp_pkg::cfp_frame_t next_frame;
  logic [7:0]          next_crc;
  logic [31:0]         fine_abs;
  logic [31:0]         coarse_ma;
  logic [31:0]         gap_ma;
  logic                tick;
  logic                load;
  logic                accept;
  logic                violation;
  logic                supply_bad;

  cfp_crc8 #(
    .NBYTES (7)
  ) u_crc (
    .data (next_frame[63:8]),
    .crc  (next_crc)
  );

  assign tick   = (q.tick_cnt == PERIOD_LAST);
  assign load   = tick && (q.fsm == cfp_pkg::ST_RUN);
  assign accept = q.frame_valid && frame_ready;

  // magnitudes; fine reading is the reference for the mismatch checks
  always_comb begin
    fine_abs  = meas.fine_ma[31] ? 32'(-meas.fine_ma) : 32'(meas.fine_ma);
    coarse_ma = 32'($signed(32'(meas.coarse_a)) * $signed(`CFP_MA_PER_A));
    gap_ma    = ($signed(meas.fine_ma) > $signed(coarse_ma))
              ? 32'(meas.fine_ma - $signed(coarse_ma))
              : 32'($signed(coarse_ma) - meas.fine_ma);
  end

  always_comb begin
    violation = 1'b0;
    if (fine_abs <= `CFP_WIN_MA) begin
      violation = (gap_ma > `CFP_GAP_MA);
    end else if (fine_abs <= `CFP_BAND_MA) begin
      // 5x avoids a divider; gap stays far below overflow
      violation = ((gap_ma * 32'h00000005) > fine_abs);
    end
  end

  assign supply_bad = supply.valid
                    && ((supply.mv < `CFP_SUPPLY_MIN_MV) || (supply.mv > `CFP_SUPPLY_MAX_MV));

  always_comb begin
    next_frame = '0;
    next_frame.rolling_frame_count = q.seq;
    next_frame.supply_state_field = supply.valid ? supply.state : `CFP_SUPPLY_NONE;
    next_frame.fault_flag = ref_fault || conv_fault || ripple_fault
                          || (fine_abs > `CFP_OVERCUR_MA);
    next_frame.plausibility_violation_flag = EXTENDED && violation;
    if (fine_abs > IMAX_MA) begin
      next_frame.fine_code = `CFP_FINE_OOR;
    end else if ($signed(meas.fine_ma) > $signed(`CFP_CLAMP_MA)) begin
      next_frame.fine_code = `CFP_FINE_POS_SAT;
    end else if ($signed(meas.fine_ma) < -$signed(`CFP_CLAMP_MA)) begin
      next_frame.fine_code = `CFP_FINE_NEG_SAT;
    end else begin
      next_frame.fine_code = 24'(32'(`CFP_FINE_ZERO) + 32'(meas.fine_ma));
    end
    if (EXTENDED) begin
      if ($signed(meas.coarse_a) > $signed(`CFP_COARSE_CLAMP)) begin
        next_frame.coarse_code = `CFP_COARSE_POS;
      end else if ($signed(meas.coarse_a) < -$signed(`CFP_COARSE_CLAMP)) begin
        next_frame.coarse_code = `CFP_COARSE_NEG;
      end else begin
        next_frame.coarse_code = `CFP_COARSE_ZERO + 16'(meas.coarse_a);
      end
    end
    next_frame.frame_check_byte = next_crc;
  end

  always_comb begin
    d = q;
    d.tick_cnt = tick ? 32'h00000000 : q.tick_cnt + 32'h00000001;
    case (q.fsm)
      cfp_pkg::ST_BOOT: begin
        if (supply_bad) begin
          d.fsm   = cfp_pkg::ST_MUTE;
          d.muted = 1'b1;
        end else begin
          d.fsm = cfp_pkg::ST_RUN;
        end
        d.tick_cnt = 32'h00000000;
      end
      cfp_pkg::ST_RUN: begin
        if (load) begin
          d.frame       = next_frame;
          d.frame_valid = 1'b1;
          d.fsm         = cfp_pkg::ST_SEND;
        end
      end
      cfp_pkg::ST_SEND: begin
        // a period tick while still waiting is dropped, not queued
        if (accept) begin
          d.frame_valid = 1'b0;
          d.fsm         = cfp_pkg::ST_RUN;
          d.seq = (q.seq == `CFP_SEQ_LAST) ? `CFP_SEQ_RESTART : q.seq + 4'h1;
        end
      end
      cfp_pkg::ST_MUTE: begin
        d.frame_valid = 1'b0;
      end
      default: begin
        d.fsm = cfp_pkg::ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign frame_valid = q.frame_valid;
  assign frame       = q.frame;
  assign tx_muted    = q.muted;
  assign frame_id    = FRAME_ID;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_FINE_OOR: assert property (
    load && (fine_abs > IMAX_MA) |=> frame.fine_code == `CFP_FINE_OOR
  ) else $error("fine code not all ones beyond maximum");

  AST_FINE_SAT: assert property (
    load && (fine_abs <= IMAX_MA) && ($signed(meas.fine_ma) > $signed(`CFP_CLAMP_MA))
    |=> frame.fine_code == `CFP_FINE_POS_SAT
  ) else $error("fine code not clamped positive");

  AST_FINE_LIN: assert property (
    load && (fine_abs <= `CFP_CLAMP_MA)
    |=> frame.fine_code == 24'(32'(`CFP_FINE_ZERO) + 32'($past(meas.fine_ma)))
  ) else $error("fine code not offset binary");

  AST_COARSE_SAT: assert property (
    load && EXTENDED && ($signed(meas.coarse_a) < -$signed(`CFP_COARSE_CLAMP))
    |=> frame.coarse_code == `CFP_COARSE_NEG
  ) else $error("coarse code not clamped negative");

  AST_SEQ_WRAP: assert property (
    accept && (q.seq == `CFP_SEQ_LAST) |=> q.seq == `CFP_SEQ_RESTART ##0 !frame_valid
  ) else $error("sequence did not wrap to one");

  AST_MUTE: assert property (
    tx_muted |-> !frame_valid ##1 tx_muted
  ) else $error("frame offered while muted");

  AST_SUPPLY_NONE: assert property (
    load && !supply.valid |=> frame.supply_state_field == 2'h3
  ) else $error("supply field not 11 without measurement");

  AST_FAULT: assert property (
    load && (ref_fault || conv_fault || ripple_fault) |=> frame.fault_flag
  ) else $error("fault flag missing");

  AST_OVERCUR: assert property (
    load && (fine_abs > `CFP_OVERCUR_MA) |=> frame.fault_flag
  ) else $error("over current not flagged");

  AST_HOLD: assert property (
    frame_valid && !frame_ready |=> frame_valid && $stable(frame)
  ) else $error("frame changed before acceptance");

  AST_RESERVED: assert property (
    frame_valid |-> (frame.spare_byte == 8'h00)
    && (EXTENDED || ((frame.coarse_code == 16'h0000) && !frame.plausibility_violation_flag))
  ) else $error("reserved field not zero");

  AST_PERIOD: assert property (
    tick |=> !tick [*8]
  ) else $error("period ticks too close");

  AST_FINE_NEG_SAT: assert property (
    load && (fine_abs <= IMAX_MA) && ($signed(meas.fine_ma) < -$signed(`CFP_CLAMP_MA))
    |=> frame.fine_code == `CFP_FINE_NEG_SAT
  ) else $error("fine code not clamped negative");

  AST_COARSE_POS: assert property (
    load && EXTENDED && ($signed(meas.coarse_a) > $signed(`CFP_COARSE_CLAMP))
    |=> frame.coarse_code == `CFP_COARSE_POS
  ) else $error("coarse code not clamped positive");

  AST_COARSE_LIN: assert property (
    load && EXTENDED && ($signed(meas.coarse_a) <= $signed(`CFP_COARSE_CLAMP))
    && ($signed(meas.coarse_a) >= -$signed(`CFP_COARSE_CLAMP))
    |=> frame.coarse_code == 16'(`CFP_COARSE_ZERO + 16'($past(meas.coarse_a)))
  ) else $error("coarse code not offset binary");

  AST_VIOL_WIN: assert property (
    load && EXTENDED && (fine_abs <= `CFP_WIN_MA) && (gap_ma > `CFP_GAP_MA)
    |=> frame.plausibility_violation_flag
  ) else $error("window mismatch not flagged");

  AST_NO_VIOL_WIN: assert property (
    load && (fine_abs <= `CFP_WIN_MA) && (gap_ma <= `CFP_GAP_MA)
    |=> !frame.plausibility_violation_flag
  ) else $error("window mismatch flagged without cause");

  // division form on purpose, so the check does not mirror the 5x product
  AST_VIOL_BAND: assert property (
    load && EXTENDED && (fine_abs > `CFP_WIN_MA) && (fine_abs <= `CFP_BAND_MA)
    && (gap_ma > (fine_abs / 32'h00000005))
    |=> frame.plausibility_violation_flag
  ) else $error("band mismatch not flagged");

  AST_NO_VIOL_HIGH: assert property (
    load && (fine_abs > `CFP_BAND_MA)
    |=> !frame.plausibility_violation_flag
  ) else $error("mismatch flagged above band");

  AST_NO_FAULT: assert property (
    load && !(ref_fault || conv_fault || ripple_fault) && (fine_abs <= `CFP_OVERCUR_MA)
    |=> !frame.fault_flag
  ) else $error("fault flag without cause");

  AST_SUPPLY_COPY: assert property (
    load && supply.valid
    |=> frame.supply_state_field == $past(supply.state)
  ) else $error("supply field not copied");

  AST_SEQ_START: assert property (
    (q.fsm == cfp_pkg::ST_BOOT) |-> (q.seq == 4'h0)
  ) else $error("sequence not zero at start");

  AST_SEQ_STEP: assert property (
    accept && (q.seq != `CFP_SEQ_LAST)
    |=> q.seq == 4'($past(q.seq) + 4'h1)
  ) else $error("sequence did not step by one");

  AST_LOAD_OFFER: assert property (
    load |=> frame_valid && (frame.rolling_frame_count == $past(q.seq))
  ) else $error("loaded frame not offered");

  AST_ACCEPT_DROP: assert property (
    accept |=> !frame_valid
  ) else $error("frame still offered after acceptance");

  AST_TICK_RESTART: assert property (
    tick |=> (q.tick_cnt == 32'h00000000)
  ) else $error("period counter did not restart");

  AST_BOOT_MUTE: assert property (
    (q.fsm == cfp_pkg::ST_BOOT) && supply_bad |=> tx_muted
  ) else $error("bad start-up supply not muted");

  AST_BOOT_RUN: assert property (
    (q.fsm == cfp_pkg::ST_BOOT) && !supply_bad |=> !tx_muted
  ) else $error("good start-up supply muted");

endmodule : cfp_packer

// ---- cfp_can_model.sv ----
// can controller stand-in that takes frames and can stall
module cfp_can_model (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rstn,
  // frame handshake
  input  wire logic                frame_valid,
  input  wire cfp_pkg::cfp_frame_t frame,
  output logic                     frame_ready,
  // test control and capture
  input  wire logic                stall,
  output cfp_pkg::cfp_frame_t      got,
  output logic [7:0]               acc_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  assign frame_ready = !stall;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      got <= '0;
      acc_cnt <= 8'h00;
    end else if (frame_valid && frame_ready) begin
      got <= frame;
      acc_cnt <= acc_cnt + 8'h01;
    end
  end
endmodule : cfp_can_model

// ---- tb_top.sv ----
// frame packer bench: field coding, sequence, stall and start-up mute
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    int f; shortint c; logic [2:0] flt; logic sv;
    logic [23:0] ef; logic [15:0] ec; logic ft; logic vi;
  } cfp_case_t;
  cfp_case_t tbl [10] = '{
    '{0, 0, 3'h0, 1'b1, 24'h800000, 16'h8000, 1'b0, 1'b0},
    '{1500000, 1500, 3'h0, 1'b1, 24'h96E360, 16'h85DC, 1'b0, 1'b0},
    '{-1500000, -1500, 3'h4, 1'b0, 24'h691CA0, 16'h7A24, 1'b1, 1'b0},
    '{1650000, 1650, 3'h0, 1'b1, 24'h97A6B0, 16'h860E, 1'b1, 1'b0},
    '{-1650000, -1650, 3'h2, 1'b1, 24'h685950, 16'h79F2, 1'b1, 1'b0},
    '{1800000, 1800, 3'h0, 1'b1, 24'hFFFFFF, 16'h860E, 1'b1, 1'b0},
    '{100000, 200, 3'h1, 1'b1, 24'h8186A0, 16'h80C8, 1'b1, 1'b1},
    '{1000000, 700, 3'h0, 1'b0, 24'h8F4240, 16'h82BC, 1'b0, 1'b1},
    '{-1, -1, 3'h0, 1'b1, 24'h7FFFFF, 16'h7FFF, 1'b0, 1'b0},
    '{1600001, 1600, 3'h0, 1'b1, 24'h97A6B0, 16'h860E, 1'b1, 1'b0}};
  logic                mclk;
  logic                rstn = 1'b0;
  cfp_pkg::cfp_meas_t  meas = '0;
  cfp_pkg::cfp_supply_t supply = '0;
  logic                ref_fault = 1'b0;
  logic                conv_fault = 1'b0;
  logic                ripple_fault = 1'b0;
  logic                stall = 1'b0;
  logic                frame_valid;
  logic                frame_ready;
  logic                tx_muted;
  logic [10:0]         frame_id;
  logic [7:0]          acc_cnt;
  cfp_pkg::cfp_frame_t frame;
  cfp_pkg::cfp_frame_t got;
  cfp_pkg::cfp_frame_t frame_b;
  logic                tx_muted_b;
  logic [3:0]          exp_seq;
  logic                steady;
  int                  errors = 0;
  int                  checks_done = 0;

  cfp_packer #(.PERIOD_CYC(20)) cfp_packer_i (.mclk(mclk), .rstn(rstn), .meas(meas), .supply(supply),
    .ref_fault(ref_fault), .conv_fault(conv_fault), .ripple_fault(ripple_fault), .frame_ready(frame_ready),
    .frame_valid(frame_valid), .frame(frame), .frame_id(frame_id), .tx_muted(tx_muted));
  // basic variant runs in lockstep with the extended one, same handshake timing
  cfp_packer #(.EXTENDED(1'b0), .PERIOD_CYC(20)) cfp_packer_basic_i (.mclk(mclk), .rstn(rstn), .meas(meas),
    .supply(supply), .ref_fault(ref_fault), .conv_fault(conv_fault), .ripple_fault(ripple_fault),
    .frame_ready(frame_ready), .frame_valid(), .frame(frame_b), .frame_id(), .tx_muted(tx_muted_b));
  cfp_can_model cfp_can_model_i (.mclk(mclk), .rstn(rstn), .frame_valid(frame_valid), .frame(frame),
    .frame_ready(frame_ready), .stall(stall), .got(got), .acc_cnt(acc_cnt));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_frame(string n, cfp_pkg::cfp_frame_t e, cfp_pkg::cfp_frame_t g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_frame

  task automatic cmp_val(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val

  // bitwise msb-first crc, own model of the check byte
  function automatic logic [7:0] crc_f(logic [55:0] d);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 55; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
    return c ^ 8'hFF;
  endfunction : crc_f

  task automatic do_reset(logic [15:0] mv);
    rstn <= 1'b0;
    supply.mv <= mv;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    exp_seq = 4'h0;
    steady = 1'b0;
  endtask : do_reset

  task automatic wait_acc(output int n);
    logic [7:0] s;
    s = acc_cnt;
    n = 0;
    while (acc_cnt === s && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      $display("CHECK FAILED accept expected frame seen none");
      wrap_up();
    end
  endtask : wait_acc

  // one frame; hold > 0 stalls the receiver across dropped ticks
  task automatic send_one(int i, int hold);
    cfp_case_t t;
    cfp_pkg::cfp_frame_t e;
    int n;
    t = tbl[i];
    meas.fine_ma <= t.f;
    meas.coarse_a <= t.c;
    {ref_fault, conv_fault, ripple_fault} <= t.flt;
    supply.valid <= t.sv;
    supply.state <= 2'h1;
    if (hold > 0) begin
      stall <= 1'b1;
      repeat (hold) @(posedge mclk);
      cmp_val("frame_valid held", 16'h1, {15'h0, frame_valid});
      stall <= 1'b0;
    end
    wait_acc(n);
    e = {exp_seq, t.sv ? 2'h1 : 2'h3, t.ft, t.vi, t.ef, t.ec, 8'h00, 8'h00};
    e.frame_check_byte = crc_f(e[63:8]);
    cmp_frame("frame", e, got);
    e.plausibility_violation_flag = 1'b0;
    e.coarse_code = 16'h0000;
    e.frame_check_byte = crc_f(e[63:8]);
    cmp_frame("basic frame", e, frame_b);
    if (hold == 0 && steady) cmp_val("period", 16'h1, {15'h0, n == 20});
    steady = (hold == 0);
    exp_seq = (exp_seq == 4'hF) ? 4'h1 : exp_seq + 4'h1;
  endtask : send_one

  // start-up supply just outside the window mutes for good
  task automatic mute_case(logic [15:0] mv);
    do_reset(mv);
    repeat (80) @(posedge mclk);
    cmp_val("tx_muted", 16'h1, {15'h0, tx_muted});
    cmp_val("tx_muted basic", 16'h1, {15'h0, tx_muted_b});
    cmp_val("frame_valid muted", 16'h0, {15'h0, frame_valid});
  endtask : mute_case

  initial begin
    do_reset(16'h2EE0);
    cmp_val("frame_id", 16'h03C2, {5'h00, frame_id});
    for (int k = 0; k < 17; k++) send_one(k % 10, 0);
    send_one(3, 60);
    send_one(6, 0);
    mute_case(16'h1E77);
    mute_case(16'h3F49);
    do_reset(16'h1E78);
    send_one(1, 0);
    send_one(7, 0);
    cmp_val("tx_muted low", 16'h0, {15'h0, tx_muted});
    do_reset(16'h3F48);
    send_one(0, 0);
    cmp_val("tx_muted top", 16'h0, {15'h0, tx_muted});
    wrap_up();
  end
endmodule : tb_top
